/* rtl/tpg_map.vh */
// Purpose: Register map, field positions and reset values of the
//          three-port GPIO block with peripheral override.
// Assumes: Register indices are multiplied by four to form byte addresses.
// Notes:   Definitions only.
//
// Summary of operation
// R01: Direction one makes first-port pin input.
// R02: Direction zero drives first-port latch onto pin.
// R03: First port eight bidirectional bits, per-bit direction.
// R04: Enabled peripheral overrides first-port direction bit.
// R05: Per-pin select chooses latch or peripheral value.
// R06: Peripheral enable counts only while selected.
// R07: Fixed peripheral sharing on first-port pins zero-seven.
// R08: First-port direction resets to all ones.
// R09: Second port eight bits, per-bit direction.
// R10: Parallel-mode bit four makes second port parallel.
// R11: Second/third ports removable by build parameter.
// R12: Third-port register: status high, bit three zero.
// R13: Third port three pins, per-bit direction.
// R14: Parallel mode: third pins are read/write/select strobes.
// R15: Software sets strobe pins input and digital first.
// R16: Analog-selected third-port pins read as zero.
// R17: Third-port direction drives pins even when analog.
// R18: After reset third-port pins are analog, read zero.
// R19: Status: word waiting, word pending, overwrite flag.
// R20: Waiting/pending read-only; overwrite/mode writable, reset zero.
// R21: Data writes set latch; reads return sampled pins.
`ifndef TPG_MAP_VH
`define TPG_MAP_VH

// ==========================================================================
// Register indices (byte address is four times the index)
// ==========================================================================
`define TPG_IDX_P1_DATA   10'h007
`define TPG_IDX_P2_DATA   10'h008
`define TPG_IDX_P3_DATA   10'h009
`define TPG_IDX_P1_DIR    10'h087
`define TPG_IDX_P2_DIR    10'h088
`define TPG_IDX_P3_DIRST  10'h089
`define TPG_IDX_ANALOG    10'h09F

// ==========================================================================
// Third-port direction/status fields
// ==========================================================================
`define TPG_BIT_WAITING   7
`define TPG_BIT_PENDING   6
`define TPG_BIT_OVERWRITE 5
`define TPG_BIT_PARALLEL  4

// ==========================================================================
// Reset values
// ==========================================================================
`define TPG_RST_DIR8      8'hFF
`define TPG_RST_DIR3      3'h7
`define TPG_RST_ANALOG    3'h7
`define TPG_RST_LATCH8    8'h00
`define TPG_RST_LATCH3    3'h0

// ==========================================================================
// Bus answers
// ==========================================================================
`define TPG_RESP_OKAY     2'h0
`define TPG_RESP_SLVERR   2'h2

`endif

/* rtl/tpg_top.v */
// Purpose: Three GPIO ports behind an AXI4-Lite slave: a first port whose
//          pins may be taken over by on-chip peripherals, a second port
//          with a parallel microprocessor mode, and a third port of three
//          strobe/analog pins.
// Assumes: Pin inputs are synchronous to aclk; peripherals sit outside.
// Notes:   Setting HAS_WIDE to zero removes the second and third ports.
`timescale 1ns/1ps
`include "tpg_map.vh"

module tpg_top #(
  parameter HAS_WIDE = 1
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [7:0]  p1_pin_i,
  output wire [7:0]  p1_pin_o,
  output wire [7:0]  p1_pin_oe,
  input  wire [7:0]  periph_sel,
  input  wire [7:0]  periph_out,
  input  wire [7:0]  periph_oe,
  output wire [7:0]  periph_in,
  input  wire [7:0]  p2_pin_i,
  output wire [7:0]  p2_pin_o,
  output wire [7:0]  p2_pin_oe,
  input  wire [2:0]  p3_pin_i,
  output wire [2:0]  p3_pin_o,
  output wire [2:0]  p3_pin_oe,
  output wire [2:0]  analog_sel
);

  // ========================================================================
  // State
  // ========================================================================
  reg  [7:0] p1_latch_r;
  reg  [7:0] p1_dir_r;
  reg  [7:0] p2_latch_r;
  reg  [7:0] p2_dir_r;
  reg  [7:0] p2_in_word_r;
  reg  [2:0] p3_latch_r;
  reg  [2:0] p3_dir_r;
  reg  [2:0] analog_r;
  reg        par_mode_r;
  reg        waiting_r;
  reg        pending_r;
  reg        overwrite_r;
  reg  [7:0] p1_samp_r;
  reg  [7:0] p2_samp_r;
  reg  [2:0] p3_samp_r;
  reg        wr_act_r;
  reg        rd_act_r;

  wire       wide = (HAS_WIDE != 0);
  wire       par  = wide & par_mode_r;

  // ========================================================================
  // Parallel-port strobes, taken from sampled third-port pins
  // ========================================================================
  // The strobes are used raw: software must already have set these pins to
  // digital inputs before enabling parallel mode.
  wire rd_n   = p3_samp_r[0];                                       // R15
  wire wr_n   = p3_samp_r[1];
  wire cs_n   = p3_samp_r[2];
  wire wr_act = par & ~cs_n & ~wr_n;                                // R14
  wire rd_act = par & ~cs_n & ~rd_n;                                // R14
  wire wr_end = wr_act_r & ~wr_act;
  wire rd_beg = rd_act & ~rd_act_r;

  // ========================================================================
  // Bus decode
  // ========================================================================
  wire       wr_go  = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire       rd_go  = s_axi_arvalid & ~s_axi_rvalid;
  wire [9:0] wr_idx = s_axi_awaddr[11:2];
  wire [9:0] rd_idx = s_axi_araddr[11:2];
  wire       wr_b0  = wr_go & s_axi_wstrb[0];
  wire [7:0] wd     = s_axi_wdata[7:0];

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;

  wire wr_p1d = wr_b0 & (wr_idx == `TPG_IDX_P1_DATA);
  wire wr_p1t = wr_b0 & (wr_idx == `TPG_IDX_P1_DIR);
  wire wr_p2d = wr_b0 & wide & (wr_idx == `TPG_IDX_P2_DATA);
  wire wr_p2t = wr_b0 & wide & (wr_idx == `TPG_IDX_P2_DIR);
  wire wr_p3d = wr_b0 & wide & (wr_idx == `TPG_IDX_P3_DATA);
  wire wr_p3t = wr_b0 & wide & (wr_idx == `TPG_IDX_P3_DIRST);
  wire wr_an  = wr_b0 & wide & (wr_idx == `TPG_IDX_ANALOG);
  wire rd_p2d = rd_go & wide & (rd_idx == `TPG_IDX_P2_DATA);

  wire wr_hit = (wr_idx == `TPG_IDX_P1_DATA) | (wr_idx == `TPG_IDX_P1_DIR) |
                (wide & ((wr_idx == `TPG_IDX_P2_DATA) |
                         (wr_idx == `TPG_IDX_P2_DIR)  |
                         (wr_idx == `TPG_IDX_P3_DATA) |
                         (wr_idx == `TPG_IDX_P3_DIRST) |
                         (wr_idx == `TPG_IDX_ANALOG)));

  // ========================================================================
  // Read data mux
  // ========================================================================
  reg [7:0] rd_byte;
  reg       rd_hit;
  wire [7:0] dir_status = {waiting_r, pending_r, overwrite_r, par_mode_r,
                           1'b0, p3_dir_r};                         // R12

  always @* begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (rd_idx)
      `TPG_IDX_P1_DATA:  rd_byte = p1_samp_r;                       // R21
      `TPG_IDX_P1_DIR:   rd_byte = p1_dir_r;
      `TPG_IDX_P2_DATA:
        if (wide) begin
          // In parallel mode the word written by the external master is
          // returned; otherwise the sampled pins are.
          rd_byte = par ? p2_in_word_r : p2_samp_r;                 // R21
        end else begin
          rd_hit = 1'b0;
        end
      `TPG_IDX_P2_DIR: begin
        rd_byte = wide ? p2_dir_r : 8'h00;
        rd_hit  = wide;
      end
      `TPG_IDX_P3_DATA: begin
        rd_byte = wide ? {5'h00, p3_samp_r & ~analog_r} : 8'h00;    // R16
        rd_hit  = wide;
      end
      `TPG_IDX_P3_DIRST: begin
        rd_byte = wide ? dir_status : 8'h00;                        // R19
        rd_hit  = wide;
      end
      `TPG_IDX_ANALOG: begin
        rd_byte = wide ? {5'h00, analog_r} : 8'h00;
        rd_hit  = wide;
      end
      default:           rd_hit  = 1'b0;
    endcase
  end

  // ========================================================================
  // Bus responses
  // ========================================================================
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TPG_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `TPG_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `TPG_RESP_OKAY : `TPG_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rd_hit ? `TPG_RESP_OKAY : `TPG_RESP_SLVERR;
        s_axi_rdata  <= {24'h000000, rd_byte};
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Pin sampling and strobe history
  // ========================================================================
  always @(posedge aclk) begin
    if (!aresetn) begin
      p1_samp_r <= 8'h00;
      p2_samp_r <= 8'h00;
      p3_samp_r <= 3'h7;
      wr_act_r  <= 1'b0;
      rd_act_r  <= 1'b0;
    end else begin
      p1_samp_r <= p1_pin_i;
      p2_samp_r <= wide ? p2_pin_i : 8'h00;
      p3_samp_r <= wide ? p3_pin_i : 3'h7;
      wr_act_r  <= wr_act;
      rd_act_r  <= rd_act;
    end
  end

  // ========================================================================
  // Configuration registers and data latches
  // ========================================================================
  always @(posedge aclk) begin
    if (!aresetn) begin
      p1_latch_r <= `TPG_RST_LATCH8;
      p1_dir_r   <= `TPG_RST_DIR8;                                  // R08
      p2_latch_r <= `TPG_RST_LATCH8;
      p2_dir_r   <= `TPG_RST_DIR8;
      p3_latch_r <= `TPG_RST_LATCH3;
      p3_dir_r   <= `TPG_RST_DIR3;                                  // R12
      analog_r   <= `TPG_RST_ANALOG;                                // R18
      par_mode_r <= 1'b0;                                           // R20
    end else begin
      if (wr_p1d) p1_latch_r <= wd;                                 // R21
      if (wr_p1t) p1_dir_r   <= wd;                                 // R03
      if (wr_p2d) p2_latch_r <= wd;                                 // R21
      if (wr_p2t) p2_dir_r   <= wd;                                 // R09
      if (wr_p3d) p3_latch_r <= wd[2:0];                            // R21
      if (wr_an)  analog_r   <= wd[2:0];
      if (wr_p3t) begin
        p3_dir_r   <= wd[2:0];                                      // R13
        par_mode_r <= wd[`TPG_BIT_PARALLEL];                        // R10
      end
    end
  end

  // ========================================================================
  // Parallel-port status flags
  // ========================================================================
  always @(posedge aclk) begin
    if (!aresetn) begin
      waiting_r    <= 1'b0;                                         // R20
      pending_r    <= 1'b0;
      overwrite_r  <= 1'b0;
      p2_in_word_r <= 8'h00;
    end else begin
      // The word is taken from the pins sampled on the same edge that saw the
      // strobes released, so the master must still hold data as it drops the strobe.
      if (wr_end) p2_in_word_r <= p2_samp_r;
      if (!par) begin
        waiting_r <= 1'b0;
        pending_r <= 1'b0;
      end else begin
        if (wr_end)      waiting_r <= 1'b1;                         // R19
        else if (rd_p2d) waiting_r <= 1'b0;
        if (wr_p2d)      pending_r <= 1'b1;                         // R19
        else if (rd_beg) pending_r <= 1'b0;
      end
      // Overwrite is sticky across mode changes; only software clears it.
      if (wr_end & waiting_r) overwrite_r <= 1'b1;                  // R19
      else if (wr_p3t) overwrite_r <= wd[`TPG_BIT_OVERWRITE];       // R20
    end
  end

  // ========================================================================
  // Pin drivers
  // ========================================================================
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_p1
      // Direction one releases the driver, zero drives the latch.
      assign p1_pin_oe[gi] = periph_sel[gi] ? periph_oe[gi]         // R04 R06
                                            : ~p1_dir_r[gi];        // R01 R02
      assign p1_pin_o[gi]  = periph_sel[gi] ? periph_out[gi]        // R05
                                            : p1_latch_r[gi];
    end
  endgenerate

  // Pin 0/1: low-rate oscillator, pin 1 also compare two, pin 2 compare
  // one, pins 3..5 serial clock/in/out, pins 6/7 USART; the peripherals
  // see the sampled pins and own their select/enable per bit.
  assign periph_in = p1_samp_r;                                     // R07

  // In parallel mode the direction register is ignored: the external
  // master reading the device is what turns the drivers on.
  assign p2_pin_oe = ~wide ? 8'h00 :
                     par   ? {8{rd_act}} : ~p2_dir_r;               // R10
  assign p2_pin_o  = wide ? p2_latch_r : 8'h00;

  // Analog selection does not release the drivers.
  assign p3_pin_oe  = wide ? ~p3_dir_r : 3'h0;                      // R17
  assign p3_pin_o   = wide ? p3_latch_r : 3'h0;
  assign analog_sel = wide ? analog_r : 3'h0;                       // R11

endmodule

/* tb/tpg_props.sv */
// Purpose: Port checks for the three-port GPIO block.
// Assumes: One clock, aclk; reset aresetn is synchronous, active low.
// Notes:   Bound into tpg_top at the foot of this file.
`timescale 1ns/1ps
module tpg_props (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_wvalid,
  input wire        s_axi_awready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [7:0]  p1_pin_i,
  input wire [7:0]  p1_pin_o,
  input wire [7:0]  p1_pin_oe,
  input wire [7:0]  periph_sel,
  input wire [7:0]  periph_out,
  input wire [7:0]  periph_oe,
  input wire [7:0]  periph_in,
  input wire [7:0]  p2_pin_oe,
  input wire [2:0]  p3_pin_oe,
  input wire [2:0]  analog_sel
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_sel_oe; ((p1_pin_oe ^ periph_oe) & periph_sel) == 8'h00;
  endproperty
  a_sel_oe: assert property (p_sel_oe) else $error("sel oe");
  property p_sel_out; ((p1_pin_o ^ periph_out) & periph_sel) == 8'h00;
  endproperty
  a_sel_out: assert property (p_sel_out) else $error("sel out");
  property p_wr_ans; s_axi_awvalid && s_axi_awready |=> s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no bvalid");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("b drop");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no rvalid");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("r drop");
  property p_rd_top; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_rd_top: assert property (p_rd_top) else $error("rdata top");
  property p_sample; $past(aresetn) |-> periph_in == $past(p1_pin_i);
  endproperty
  a_sample: assert property (p_sample) else $error("pin sample");
  property p_ready; s_axi_awready |->
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid; endproperty
  a_ready: assert property (p_ready) else $error("awready");
  property p_rst; disable iff (1'b0) !aresetn |=> analog_sel == 3'h7 &&
    p2_pin_oe == 8'h00 && p3_pin_oe == 3'h0 &&
    (p1_pin_oe & ~periph_sel) == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule
bind tpg_top tpg_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .p1_pin_i(p1_pin_i), .p1_pin_o(p1_pin_o),
  .p1_pin_oe(p1_pin_oe), .periph_sel(periph_sel), .periph_out(periph_out),
  .periph_oe(periph_oe), .periph_in(periph_in), .p2_pin_oe(p2_pin_oe),
  .p3_pin_oe(p3_pin_oe), .analog_sel(analog_sel));

/* tb/tpg_board.sv */
// Purpose: Board model that resolves every pin from block and board.
// Assumes: An undriven pin takes the board value set by the bench.
// Notes:   No pull-ups, so the bench changes board values often.
`timescale 1ns/1ps
module tpg_board (
  input  wire [7:0] p1_o,
  input  wire [7:0] p1_oe,
  input  wire [7:0] p1_ext,
  input  wire [7:0] p2_o,
  input  wire [7:0] p2_oe,
  input  wire [7:0] p2_ext,
  input  wire [2:0] p3_o,
  input  wire [2:0] p3_oe,
  input  wire [2:0] p3_ext,
  output wire [7:0] p1_i,
  output wire [7:0] p2_i,
  output wire [2:0] p3_i
);
  assign p1_i = (p1_oe & p1_o) | (~p1_oe & p1_ext);
  assign p2_i = (p2_oe & p2_o) | (~p2_oe & p2_ext);
  // Strobes idle high and are only lowered with the pins set as inputs.
  assign p3_i = (p3_oe & p3_o) | (~p3_oe & p3_ext);
endmodule

/* tb/testbench.sv */
// Purpose: Self-checking bench for the three-port GPIO block.
// Assumes: Default build with all three ports present.
// Notes:   Register traffic uses AXI4-Lite with response delays taken from the cycle count.
`timescale 1ns/1ps
`include "tpg_map.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  n_errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000, seed = 32'h00000015;
  logic [7:0]  sel = 8'h00, pout = 8'h00, poe = 8'h00;
  logic [7:0]  e1 = 8'h00, e2 = 8'h00, d, v, s;
  logic [2:0]  e3 = 3'h7;
  wire         awready, bvalid, arready, rvalid;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [7:0]   p1i, p1o, p1oe, p2i, p2o, p2oe;
  wire [2:0]   p3i, p3o, p3oe, asel;
  int          n_errors = 0, samples_checked = 0, cyc = 0;
  tpg_top dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .p1_pin_i(p1i),
    .p1_pin_o(p1o), .p1_pin_oe(p1oe), .periph_sel(sel), .periph_out(pout),
    .periph_oe(poe), .periph_in(), .p2_pin_i(p2i), .p2_pin_o(p2o),
    .p2_pin_oe(p2oe), .p3_pin_i(p3i), .p3_pin_o(p3o), .p3_pin_oe(p3oe),
    .analog_sel(asel));
  tpg_board board (.p1_o(p1o), .p1_oe(p1oe), .p1_ext(e1), .p2_o(p2o),
    .p2_oe(p2oe), .p2_ext(e2), .p3_o(p3o), .p3_oe(p3oe), .p3_ext(e3),
    .p1_i(p1i), .p2_i(p2i), .p3_i(p3i));
  // ==========================================================
  // Clock, watchdog, helpers
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      report_and_stop;
    end
  end
  function automatic [31:0] xs(input [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    xs = x;
  endfunction
  function automatic [7:0] mux8(input [7:0] m, input [7:0] a, b);
    mux8 = (m & a) | (~m & b);
  endfunction
  task automatic wr(input [9:0] ix, input [7:0] dv, input [1:0] er);
    awaddr <= {ix, 2'b00};
    wdata <= {24'h000000, dv};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // Ready and valid are looked at mid-cycle, where they have settled,
    // so the taking edge is known before it comes.
    @(negedge aclk);
    while (awready !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    repeat (cyc[1:0]) @(posedge aclk);
    bready <= 1'b1;
    @(negedge aclk);
    while (bvalid !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask
  task automatic rd(input [9:0] ix, input [7:0] ev, input [1:0] er);
    araddr <= {ix, 2'b00};
    arvalid <= 1'b1;
    @(negedge aclk);
    while (arready !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 1'b0;
    repeat (cyc[1:0]) @(posedge aclk);
    rready <= 1'b1;
    @(negedge aclk);
    while (rvalid !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    rready <= 1'b0;
    `CHK(rresp, er)
    if (er == 2'h0) `CHK(rdata, {24'h000000, ev})
  endtask
  // One strobe cycle from the far bus; strobes are held three edges.
  task automatic ext_cyc(input [2:0] st, input [7:0] dv, input [7:0] eoe);
    e2 <= dv;
    e3 <= st;
    repeat (3) @(posedge aclk);
    `CHK(p2oe, eoe)
    e3 <= 3'h7;
    repeat (4) @(posedge aclk);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    e3 <= 3'h5;
    @(posedge aclk);
    `CHK(asel, 3'h7)
    `CHK(p1oe, 8'h00)
    rd(`TPG_IDX_P1_DIR, 8'hFF, 2'h0);
    rd(`TPG_IDX_P2_DIR, 8'hFF, 2'h0);
    rd(`TPG_IDX_P3_DIRST, 8'h07, 2'h0);
    rd(`TPG_IDX_P3_DATA, 8'h00, 2'h0);
    wr(10'h010, 8'h55, 2'h2);
    rd(10'h010, 8'h00, 2'h2);
    $display("reset and map test done");
    for (int i = 0; i < 24; i++) begin
      sel <= 8'h00;
      seed = xs(seed);
      d = seed[7:0];
      v = seed[15:8];
      e1 <= seed[23:16];
      e2 <= seed[31:24];
      wr(`TPG_IDX_P1_DIR, d, 2'h0);
      wr(`TPG_IDX_P1_DATA, v, 2'h0);
      wr(`TPG_IDX_P2_DIR, ~d, 2'h0);
      wr(`TPG_IDX_P2_DATA, ~v, 2'h0);
      `CHK(p1oe, ~d)
      `CHK(p1o, v)
      `CHK(p2oe, d)
      rd(`TPG_IDX_P1_DATA, mux8(~d, v, e1), 2'h0);
      rd(`TPG_IDX_P2_DATA, mux8(d, ~v, e2), 2'h0);
      seed = xs(seed);
      s = (i == 0) ? 8'hFF : seed[7:0];
      sel <= s;
      pout <= seed[15:8];
      poe <= seed[23:16];
      @(posedge aclk);
      `CHK(p1oe, mux8(s, seed[23:16], ~d))
      `CHK(p1o, mux8(s, seed[15:8], v))
    end
    sel <= 8'h00;
    $display("port one and two test done");
    wr(`TPG_IDX_ANALOG, 8'h00, 2'h0);
    rd(`TPG_IDX_P3_DATA, 8'h05, 2'h0);
    wr(`TPG_IDX_P3_DIRST, 8'h02, 2'h0);
    wr(`TPG_IDX_P3_DATA, 8'h03, 2'h0);
    `CHK(p3oe, 3'h5)
    rd(`TPG_IDX_P3_DATA, 8'h01, 2'h0);
    wr(`TPG_IDX_ANALOG, 8'h07, 2'h0);
    `CHK(p3oe, 3'h5)
    wr(`TPG_IDX_ANALOG, 8'h00, 2'h0);
    e3 <= 3'h7;
    wr(`TPG_IDX_P3_DIRST, 8'hFF, 2'h0);
    rd(`TPG_IDX_P3_DIRST, 8'h37, 2'h0);
    wr(`TPG_IDX_P3_DIRST, 8'h17, 2'h0);
    wr(`TPG_IDX_P2_DIR, 8'h00, 2'h0);
    ext_cyc(3'h1, 8'hA5, 8'h00);
    rd(`TPG_IDX_P3_DIRST, 8'h97, 2'h0);
    ext_cyc(3'h1, 8'h3C, 8'h00);
    rd(`TPG_IDX_P3_DIRST, 8'hB7, 2'h0);
    rd(`TPG_IDX_P2_DATA, 8'h3C, 2'h0);
    rd(`TPG_IDX_P3_DIRST, 8'h37, 2'h0);
    wr(`TPG_IDX_P2_DATA, 8'h6E, 2'h0);
    rd(`TPG_IDX_P3_DIRST, 8'h77, 2'h0);
    ext_cyc(3'h2, 8'h00, 8'hFF);
    `CHK(p2o, 8'h6E)
    rd(`TPG_IDX_P3_DIRST, 8'h37, 2'h0);
    wr(`TPG_IDX_P3_DIRST, 8'h07, 2'h0);
    ext_cyc(3'h1, 8'h11, 8'hFF);
    rd(`TPG_IDX_P3_DIRST, 8'h07, 2'h0);
    $display("parallel port test done");
    report_and_stop;
  end
endmodule
